// >>> verilog/autoneg_ability_registers.sv
// Purpose: Auto-negotiation advertisement, partner ability and expansion registers
//          reached over the serial management link.
// Assumes: Negotiation events arrive on sys_clk; mdc, mdio and straps are pins.
// Notes:   Only registers 4..6 answer; other numbers are left to other blocks.
`timescale 1ns/10ps
`default_nettype none

module autoneg_ability_registers
   import an_regs_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = 5'h00
)
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic [2:0] strap_mode_select,
   input  wire logic       mdc,
   input  wire logic       mdio_in,
   output logic            mdio_out,
   output logic            mdio_oe_n,
   input  wire an_event_s  an_event,
   output logic [15:0]     local_advert
);

   typedef struct packed
   {
      frame_state_e fsm;
      logic [5:0]   pre_cnt;
      logic [4:0]   bit_cnt;
      logic [1:0]   op;
      logic [9:0]   addr;
      logic [15:0]  shreg;
      logic [15:0]  tx_word;
      logic         rd_frame;
      logic [2:0]   mdc_sync;
      logic [2:0]   mdio_sync;
      logic         mdc_lvl;
      logic         mdio_lvl;
      logic [2:0]   strap_s1;
      logic [2:0]   strap_s2;
      logic [2:0]   strap_s3;
      logic [1:0]   strap_cnt;
      logic         strap_pending;
      logic         adv_rf;
      logic [1:0]   adv_pause;
      logic         adv_100fd;
      logic         adv_100hd;
      logic         adv_10fd;
      logic         adv_10hd;
      logic [4:0]   adv_sel;
      logic [15:0]  lp_word;
      logic         lp_ack;
      logic         pd_fault;
      logic         page_rx;
      logic         lp_an_able;
      logic         mdio_out;
      logic         mdio_oe_n;
      logic [15:0]  advert;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   // Combinational register views and decode helpers
   logic [15:0] reg4_val;
   logic [15:0] reg5_val;
   logic [15:0] reg6_val;
   logic        mdc_rise;
   logic        bit_in;
   logic        hit;
   logic [4:0]  regad;

   // Read views of the three registers
   always_comb
   begin
      reg4_val = {1'b0,
                  1'b0,
                  st_r.adv_rf,
                  1'b0,
                  st_r.adv_pause,
                  1'b0,
                  st_r.adv_100fd,
                  st_r.adv_100hd,
                  st_r.adv_10fd,
                  st_r.adv_10hd,
                  st_r.adv_sel};
      reg5_val = {1'b0,
                  st_r.lp_ack,
                  st_r.lp_word[POS_REMOTE_FAULT],
                  2'h0,
                  st_r.lp_word[POS_PAUSE_LO],
                  st_r.lp_word[9:5],
                  st_r.lp_word[POS_SEL_HI:0]};
      reg6_val = {11'h000,
                  st_r.pd_fault,
                  st_r.lp_word[POS_NEXT_PAGE],
                  1'b0,
                  st_r.page_rx,
                  st_r.lp_an_able};
   end

   // Pin edge and address decode helpers
   always_comb
   begin
      mdc_rise = 1'b0;
      // One cycle per rise, as mdc_lvl follows at the next edge
      // Edge only counts once the second and third stages agree
      if (st_r.mdc_sync[1] == st_r.mdc_sync[2] && st_r.mdc_sync[2] && !st_r.mdc_lvl)
      begin
         mdc_rise = 1'b1;
      end
      bit_in = st_r.mdio_lvl;
      regad  = st_r.addr[4:0];
      hit    = (st_r.addr[9:5] == PHY_ADDR) &&
               (regad == REG_LOCAL_ADVERTISE || regad == REG_PARTNER_ABILITY ||
                regad == REG_EXPANSION_STATUS);
   end

   // Next-state logic for everything
   always_comb
   begin
      st_nxt = st_r;

      // Pin synchronisers; only stages 2 and 3 are looked at
      st_nxt.mdc_sync  = {st_r.mdc_sync[1:0], mdc};
      st_nxt.mdio_sync = {st_r.mdio_sync[1:0], mdio_in};
      if (st_r.mdc_sync[1] == st_r.mdc_sync[2])
      begin
         st_nxt.mdc_lvl = st_r.mdc_sync[2];
      end
      if (st_r.mdio_sync[1] == st_r.mdio_sync[2])
      begin
         st_nxt.mdio_lvl = st_r.mdio_sync[2];
      end
      st_nxt.strap_s1 = strap_mode_select;
      st_nxt.strap_s2 = st_r.strap_s1;
      st_nxt.strap_s3 = st_r.strap_s2;

      // Straps are taken once the synchroniser has filled after reset
      if (st_r.strap_pending)
      begin
         // Second and third stages must agree, as for the other pins
         // Straps are read once; later pin changes need a reset
         if (st_r.strap_cnt == STRAP_SETTLE && st_r.strap_s2 == st_r.strap_s3)
         begin
            st_nxt.strap_pending = 1'b0;
            st_nxt.adv_100fd = st_r.strap_s3[STRAP_POS_100_FULL];
            st_nxt.adv_10fd  = st_r.strap_s3[STRAP_POS_10_FULL];
            st_nxt.adv_10hd  = st_r.strap_s3[STRAP_POS_10_HALF];
         end
         else
         begin
            st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
         end
      end

      // Frame sequencer advances on each mdc rising edge
      if (mdc_rise)
      begin
         case (st_r.fsm)
            ST_IDLE:
            begin
               // Count saturates; fewer than 32 ones never start a frame
               if (bit_in)
               begin
                  if (st_r.pre_cnt != PREAMBLE_ONES)
                  begin
                     st_nxt.pre_cnt = st_r.pre_cnt + 6'h01;
                  end
               end
               else
               begin
                  st_nxt.pre_cnt = 6'h00;
                  if (st_r.pre_cnt == PREAMBLE_ONES)
                  begin
                     st_nxt.fsm = ST_START;
                  end
               end
            end
            ST_START:
            begin
               // A second zero drops back to hunting for preamble
               st_nxt.bit_cnt = 5'h00;
               st_nxt.fsm     = bit_in ? ST_OP : ST_IDLE;
            end
            ST_OP:
            begin
               st_nxt.op      = {st_r.op[0], bit_in};
               st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
               if (st_r.bit_cnt == 5'h01)
               begin
                  st_nxt.bit_cnt = 5'h00;
                  st_nxt.fsm     = ST_ADDR;
               end
            end
            ST_ADDR:
            begin
               st_nxt.addr    = {st_r.addr[8:0], bit_in};
               st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
               if (st_r.bit_cnt == ADDR_BITS - 5'h01)
               begin
                  st_nxt.bit_cnt = 5'h00;
                  st_nxt.fsm     = ST_TA;
               end
            end
            ST_TA:
            begin
               st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
               if (st_r.bit_cnt == 5'h00)
               begin
                  // Only our own address and registers 4..6 answer
                  st_nxt.rd_frame = (st_r.op == OP_READ) && hit;
                  if (st_r.op == OP_READ && hit)
                  begin
                     // Snapshot, then drive the second turnaround bit low
                     st_nxt.mdio_oe_n = 1'b0;
                     st_nxt.mdio_out  = 1'b0;
                     st_nxt.tx_word   = (regad == REG_LOCAL_ADVERTISE) ? reg4_val :
                                        (regad == REG_PARTNER_ABILITY) ? reg5_val :
                                        reg6_val;
                     if (regad == REG_EXPANSION_STATUS)
                     begin
                        st_nxt.pd_fault = 1'b0;
                        st_nxt.page_rx  = 1'b0;
                     end
                  end
               end
               else
               begin
                  st_nxt.bit_cnt = 5'h00;
                  st_nxt.fsm     = ST_DATA;
                  if (st_r.rd_frame)
                  begin
                     st_nxt.mdio_out = st_r.tx_word[15];
                     st_nxt.tx_word  = {st_r.tx_word[14:0], 1'b0};
                  end
               end
            end
            ST_DATA:
            begin
               st_nxt.shreg   = {st_r.shreg[14:0], bit_in};
               st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
               if (st_r.rd_frame)
               begin
                  st_nxt.mdio_out = st_r.tx_word[15];
                  st_nxt.tx_word  = {st_r.tx_word[14:0], 1'b0};
               end
               if (st_r.bit_cnt == DATA_BITS - 5'h01)
               begin
                  st_nxt.fsm       = ST_IDLE;
                  st_nxt.pre_cnt   = 6'h00;
                  st_nxt.rd_frame  = 1'b0;
                  // Release the line straight after the last data bit
                  st_nxt.mdio_oe_n = 1'b1;
                  st_nxt.mdio_out  = 1'b0;
                  if (st_r.op == OP_WRITE && hit && regad == REG_LOCAL_ADVERTISE)
                  begin
                     // Only writable fields take the word
                     st_nxt.adv_rf    = st_r.shreg[POS_REMOTE_FAULT - 1];
                     st_nxt.adv_pause = st_r.shreg[POS_PAUSE_HI-1:POS_PAUSE_LO-1];
                     st_nxt.adv_100fd = st_r.shreg[POS_100_FULL - 1];
                     st_nxt.adv_100hd = st_r.shreg[POS_100_HALF - 1];
                     st_nxt.adv_10fd  = st_r.shreg[POS_10_FULL - 1];
                     st_nxt.adv_10hd  = st_r.shreg[POS_10_HALF - 1];
                     st_nxt.adv_sel   = {st_r.shreg[3:0], bit_in};
                  end
                  // Bits 15, 14, 12, 9 and registers 5, 6 drop the write
               end
            end
            default:
            begin
               st_nxt.fsm = ST_IDLE;
            end
         endcase
      end

      // Events arrive on sys_clk, so they need no synchroniser
      // Negotiation engine updates; a set wins over a read clear
      if (an_event.lp_word_valid)
      begin
         st_nxt.lp_word = an_event.lp_word;
         st_nxt.lp_ack  = 1'b1;
      end
      if (an_event.pd_fault)
      begin
         st_nxt.pd_fault = 1'b1;
      end
      if (an_event.page_rx)
      begin
         st_nxt.page_rx = 1'b1;
      end
      st_nxt.lp_an_able = an_event.lp_an_able;
      st_nxt.advert     = reg4_val;

      // Synchronous reset values
      // Straps reload after every reset, mid-run too
      if (rst)
      begin
         st_nxt               = '0;
         st_nxt.fsm           = ST_IDLE;
         st_nxt.strap_pending = 1'b1;
         st_nxt.mdio_oe_n     = 1'b1;
         st_nxt.adv_rf        = RFAULT_RESET;
         st_nxt.adv_pause     = PAUSE_RESET;
         st_nxt.adv_100hd     = ADV_100HALF_RESET;
         st_nxt.adv_sel       = SELECTOR_RESET;
         st_nxt.lp_word       = {11'h000, SELECTOR_RESET};
      end
   end

   // State register
   always_ff @(posedge sys_clk)
   begin
      st_r <= st_nxt;
   end

   // Outputs come straight from the state register
   assign mdio_out     = st_r.mdio_out;
   assign mdio_oe_n    = st_r.mdio_oe_n;
   assign local_advert = st_r.advert;

endmodule

`default_nettype wire

// >>> verilog/an_regs_pkg.sv
// Purpose: Shared constants and types of the auto-negotiation register bank.
// Assumes: Management frames are the usual serial management frames, 16-bit registers.
// Notes:   Offsets are 5-bit register numbers on the serial management link.
`default_nettype none
package an_regs_pkg;

   // Register numbers
   localparam logic [4:0] REG_LOCAL_ADVERTISE   = 5'h04;
   localparam logic [4:0] REG_PARTNER_ABILITY   = 5'h05;
   localparam logic [4:0] REG_EXPANSION_STATUS  = 5'h06;

   // Field positions in the advertisement and partner words
   localparam int POS_REMOTE_FAULT = 13;
   localparam int POS_ACK          = 14;
   localparam int POS_NEXT_PAGE    = 15;
   localparam int POS_PAUSE_HI     = 11;
   localparam int POS_PAUSE_LO     = 10;
   localparam int POS_100_FULL     = 8;
   localparam int POS_100_HALF     = 7;
   localparam int POS_10_FULL      = 6;
   localparam int POS_10_HALF      = 5;
   localparam int POS_SEL_HI       = 4;

   // Values after reset
   localparam logic [4:0] SELECTOR_RESET   = 5'h01;
   localparam logic [1:0] PAUSE_RESET      = 2'h0;
   localparam logic       RFAULT_RESET     = 1'h0;
   localparam logic       ADV_100HALF_RESET = 1'h1;

   // Strap bit that seeds each strap-defaulted ability
   localparam int STRAP_POS_100_FULL = 2;
   localparam int STRAP_POS_10_FULL  = 1;
   localparam int STRAP_POS_10_HALF  = 0;

   // Frame and strap counts, opcodes
   localparam logic [5:0] PREAMBLE_ONES = 6'h20;
   localparam logic [4:0] ADDR_BITS     = 5'h0A;
   localparam logic [4:0] DATA_BITS     = 5'h10;
   localparam logic [1:0] STRAP_SETTLE  = 2'h3;
   localparam logic [1:0] OP_WRITE      = 2'h1;
   localparam logic [1:0] OP_READ       = 2'h2;

   // Frame sequencer states, one-hot
   typedef enum logic [5:0]
   {
      ST_IDLE  = 6'h01,
      ST_START = 6'h02,
      ST_OP    = 6'h04,
      ST_ADDR  = 6'h08,
      ST_TA    = 6'h10,
      ST_DATA  = 6'h20
   } frame_state_e;

   // Events and levels from the negotiation engine
   typedef struct packed
   {
      logic        lp_word_valid;
      logic [15:0] lp_word;
      logic        page_rx;
      logic        pd_fault;
      logic        lp_an_able;
   } an_event_s;

endpackage
`default_nettype wire

// >>> testbench/an_regs_monitor.sv
// Purpose: Port-level checks of the auto-negotiation register bank.
// Assumes: local_advert mirrors register 4, one cycle behind.
// Notes:   Reset defaults are allowed a short landing window.
`timescale 1ns/10ps
`default_nettype none
module an_regs_monitor
   import an_regs_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic [2:0]  strap_mode_select,
   input wire logic        mdc,
   input wire logic        mdio_in,
   input wire logic        mdio_out,
   input wire logic        mdio_oe_n,
   input wire an_event_s   an_event,
   input wire logic [15:0] local_advert
);
   // One clock domain, one reset
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // Straps land on abilities 8, 6 and 5
   wire logic [15:0] strap_view = {7'h00, strap_mode_select[2], 1'h0,
      strap_mode_select[1], strap_mode_select[0], 5'h00};

   a_next_page_zero:
      assert property (local_advert[POS_NEXT_PAGE] == 1'h0) else $error("next page set");
   a_four_pair_zero:
      assert property (local_advert[9] == 1'h0) else $error("four-pair bit set");
   a_rsvd_fourteen:
      assert property (!local_advert[POS_ACK]) else $error("bit 14 set");
   a_rsvd_twelve:
      assert property (!local_advert[12]) else $error("bit 12 set");
   a_select_default:
      assert property ($fell(rst) |-> ##[2:6] local_advert[4:0] == SELECTOR_RESET)
      else $error("selector default wrong");
   a_pause_default:
      assert property ($fell(rst) |-> ##[2:6] local_advert[11:10] == PAUSE_RESET)
      else $error("pause default wrong");
   a_strap_default:
      assert property ($fell(rst) |-> ##[2:6] local_advert == (16'h0081 | strap_view))
      else $error("strap default wrong");
   // A read of the bank never disturbs the advertisement
   a_advert_quiet:
      assert property (!mdio_oe_n |=> $stable(local_advert)) else $error("advert moved");

   c_read: cover property ($fell(mdio_oe_n));
   c_write: cover property ($changed(local_advert));
   c_reset: cover property ($fell(rst));
endmodule
bind autoneg_ability_registers an_regs_monitor i_mon (.sys_clk, .rst, .strap_mode_select,
   .mdc, .mdio_in, .mdio_out, .mdio_oe_n, .an_event, .local_advert);
`default_nettype wire

// >>> testbench/smi_station.sv
// Purpose: Station manager model that frames management reads and writes.
// Assumes: The data line has a pull-up; mdc parks low between frames.
// Notes:   Each mdc half period is six system clocks.
`timescale 1ns/10ps
`default_nettype none
module smi_station
   import an_regs_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic mdio_out,
   input  wire logic mdio_oe_n,
   output logic      mdc,
   output logic      mdio_in
);
   logic drv_en = 1'h0;
   logic drv_bit = 1'h0;

   // Wire level: station, else device, else the pull-up
   assign mdio_in = drv_en ? drv_bit : (mdio_oe_n ? 1'h1 : mdio_out);

   initial
   begin
      mdc = 1'h0;
   end

   // Whole frame; read bits sampled late in the low phase, when settled
   task automatic xfer(input logic wr, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] f;
      f = {32'hFFFFFFFF, 2'h1, wr ? OP_WRITE : OP_READ, phy, ra, 2'h2, wd};
      rd = 16'h0000;
      for (int i = 63; i >= 0; i--)
      begin
         drv_en = wr || i > 17;
         drv_bit = f[i];
         mdc = 1'h0;
         repeat (6) @(posedge sys_clk);
         #2;
         if (i < 16)
            rd[i] = mdio_in;
         mdc = 1'h1;
         repeat (6) @(posedge sys_clk);
         #2;
      end
      mdc = 1'h0;
      drv_en = 1'h0;
      // Idle low phase, so back-to-back frames never retouch a pin at once
      repeat (6) @(posedge sys_clk);
      #2;
   endtask
endmodule
`default_nettype wire

// >>> testbench/autoneg_ability_registers_test.sv
// Purpose: Self-checking bench for the auto-negotiation register bank.
// Assumes: The station model does the framing; results pass a queue.
// Notes:   Straps and data come from an 8-bit shift register seeded 44.
`timescale 1ns/10ps
`default_nettype none
module autoneg_ability_registers_test
   import an_regs_pkg::*;
   ;
   logic        sys_clk = 1'h0;
   logic        rst = 1'h1;
   logic [2:0]  straps;
   an_event_s   ev;
   wire logic   mdc;
   wire logic   mdio_in;
   wire logic   mdio_out;
   wire logic   mdio_oe_n;
   wire logic [15:0] advert;
   logic [7:0]  lfsr = 8'h2C;
   logic [15:0] exp_q[$];
   logic [15:0] got_q[$];
   string       name_q[$];
   int          miscompares = 0;
   int          checks_done = 0;
   int          cycles = 0;

   always #12.5 sys_clk = ~sys_clk;

   autoneg_ability_registers i_dut (.sys_clk, .rst, .strap_mode_select(straps), .mdc,
      .mdio_in, .mdio_out, .mdio_oe_n, .an_event(ev), .local_advert(advert));
   smi_station i_smi (.sys_clk, .mdio_out, .mdio_oe_n, .mdc, .mdio_in);

   // Maximal taps, so the pattern has no short cycle
   function automatic void rnd(output logic [15:0] r);
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      r[15:8] = lfsr;
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      r[7:0] = lfsr;
   endfunction

   task automatic check16(input string what, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic rd(input string what, input logic [4:0] phy, input logic [4:0] ra,
                     input logic [15:0] e);
      logic [15:0] d;
      exp_q.push_back(e);
      name_q.push_back(what);
      i_smi.xfer(1'h0, phy, ra, 16'h0000, d);
      got_q.push_back(d);
   endtask

   task automatic wr(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] d);
      logic [15:0] unused;
      i_smi.xfer(1'h1, phy, ra, d, unused);
   endtask

   // View port trails a write by a few cycles
   task automatic adv(input logic [15:0] e);
      repeat (4) @(posedge sys_clk);
      #2;
      exp_q.push_back(e);
      name_q.push_back("advert");
      got_q.push_back(advert);
   endtask

   task automatic pulse(input logic [2:0] which, input logic [15:0] w);
      {ev.lp_word_valid, ev.page_rx, ev.pd_fault} = which;
      ev.lp_word = w;
      @(posedge sys_clk);
      #2 {ev.lp_word_valid, ev.page_rx, ev.pd_fault} = 3'h0;
   endtask

   task automatic results();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Oldest note against each result
   always @(posedge sys_clk)
   begin
      while (got_q.size() > 0)
         check16(name_q.pop_front(), exp_q.pop_front(), got_q.pop_front());
   end

   // Cut a hang short
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         miscompares++;
         results();
      end
   end

   // Second pass is a reset in mid-run with fresh straps
   initial
   begin
      logic [15:0] r;
      logic [15:0] w;
      logic [15:0] dflt;
      for (int pass = 0; pass < 2; pass++)
      begin
         rnd(r);
         straps = r[2:0];
         rst = 1'h1;
         ev = 20'h00000;
         repeat (4) @(posedge sys_clk);
         #2 rst = 1'h0;
         repeat (8) @(posedge sys_clk);
         #2;
         dflt = 16'h0081 | {7'h00, straps[2], 1'h0, straps[1], straps[0], 5'h00};
         adv(dflt);
         rd("adv", 5'h00, REG_LOCAL_ADVERTISE, dflt);
         rd("ptn", 5'h00, REG_PARTNER_ABILITY, 16'h0001);
         rd("exp", 5'h00, REG_EXPANSION_STATUS, 16'h0000);
         if (pass == 0)
         begin
            wr(5'h00, REG_LOCAL_ADVERTISE, 16'hFFFF);
            rd("adv ro", 5'h00, REG_LOCAL_ADVERTISE, 16'h2DFF);
            for (int p = 0; p < 4; p++)
            begin
               rnd(r);
               w = (r & 16'h21FF) | {4'h0, p[1:0], 10'h000};
               wr(5'h00, REG_LOCAL_ADVERTISE, w);
               adv(w);
               rd("pause", 5'h00, REG_LOCAL_ADVERTISE, w);
            end
            wr(5'h01, REG_LOCAL_ADVERTISE, 16'h0000);
            rd("other phy", 5'h01, REG_LOCAL_ADVERTISE, 16'hFFFF);
            adv(w);
            wr(5'h00, REG_PARTNER_ABILITY, 16'hFFFF);
            wr(5'h00, REG_EXPANSION_STATUS, 16'hFFFF);
            rd("ptn ro", 5'h00, REG_PARTNER_ABILITY, 16'h0001);
            rd("exp ro", 5'h00, REG_EXPANSION_STATUS, 16'h0000);
            rnd(r);
            ev.lp_an_able = 1'h1;
            pulse(3'h4, r | 16'h8000);
            rd("word", 5'h00, REG_PARTNER_ABILITY, {2'h1, r[13], 2'h0, r[10:0]});
            pulse(3'h3, r);
            rd("latched", 5'h00, REG_EXPANSION_STATUS, 16'h001B);
            rd("cleared", 5'h00, REG_EXPANSION_STATUS, 16'h0009);
            pulse(3'h2, r);
            rd("page", 5'h00, REG_EXPANSION_STATUS, 16'h000B);
         end
      end
      repeat (2) @(posedge sys_clk);
      results();
   end
endmodule
`default_nettype wire
